// [hdl/sfr_bank.sv]
// Function
// - Every register except 00h, 1Ah and 1Eh is held in storage cells that keep their value while powered.
// - Unimplemented locations read as zero; writes to them do nothing.
// - Location 00h has no storage; it accesses the word the pointer selects.
// - Port A write loads the output latch; read returns the pin levels.
// - Transmit data register clears to zero on reset.
// - Second capture low byte keeps its contents across reset.
// - Conversion result byte is readable at 1Eh, undefined after reset.
// - Upper counter not readable; latch is copied into it on branches.
// - Common core registers decode identically from every bank.
//
// Register access over APB was chosen for this implementation.
`default_nettype none
module sfr_bank
   import sfr_bank_pkg::*;
(
   input  wire logic               ref_clk,
   input  wire logic               reset,
   input  wire logic               psel,
   input  wire logic               penable,
   input  wire logic               pwrite,
   input  wire logic [PADDR_W-1:0] paddr,
   input  wire logic [31:0]        pwdata,
   input  wire logic [3:0]         pstrb,
   output logic                    pready,
   output logic                    pslverr,
   output logic [31:0]             prdata,
   input  wire logic [7:0]         port_a_pins,
   output logic [7:0]              port_a_latch,
   output logic [7:0]              async_transmit_data,
   output logic                    tx_load,
   input  wire logic [7:0]         async_receive_data,
   input  wire logic [7:0]         conversion_result_high,
   input  wire logic               branch_take,
   output logic [4:0]              pc_high,
   output logic                    sfr_wr_stb,
   output logic [4:0]              sfr_wr_index,
   output logic [7:0]              sfr_wr_data
);

   ////////////////////////////////////////////////////////////////////////////
   // Address decode

   logic [7:0]  sfr_q [SFR_COUNT];
   logic [7:0]  gpr_q [GPR_DEPTH];
   logic [8:0]  dir_map;
   logic [8:0]  ind_map;
   logic [8:0]  eff_map;
   logic        use_ind;
   logic        sfr_hit;
   logic        gpr_hit;
   logic [6:0]  eff_idx;
   logic [4:0]  sfr_sel;
   logic        setup;
   logic        wr_en;
   logic [7:0]  rd_byte;
   logic [31:0] prdata_q;
   logic [4:0]  pc_high_q;
   logic        tx_load_q;
   logic        wr_stb_q;
   logic [4:0]  wr_index_q;
   logic [7:0]  wr_data_q;

   // Result: {sfr hit, gpr hit, index}
   function automatic logic [8:0] map_loc(input logic [8:0] loc);
      logic [6:0] low;
      logic       common;
      low = loc[6:0];
      common = (low < GPR_BASE) && COMMON_MASK[low[4:0]];
      map_loc = 9'h000;
      if (((loc[8:7] == 2'b00) && (low < GPR_BASE)) || common)
      begin
         map_loc = {2'b10, low};
      end
      else if ((low >= COMMON_BASE) || (loc[8:7] == 2'b00))
      begin
         map_loc = {2'b01, 7'(low - GPR_BASE)};
      end
   endfunction

   assign dir_map = map_loc(paddr[10:2]);
   assign ind_map = map_loc({sfr_q[IDX_STATUS][STATUS_IRP_BIT], sfr_q[IDX_POINTER]});
   assign use_ind = dir_map[8] && (dir_map[6:0] == 7'h00);

   always_comb
   begin
      eff_map = dir_map;
      if (use_ind)
      begin
         // Pointer aimed back at the window itself reaches nothing
         eff_map = (ind_map[8] && (ind_map[6:0] == 7'h00)) ? 9'h000 : ind_map;
      end
   end

   assign sfr_hit = eff_map[8];
   assign gpr_hit = eff_map[7];
   assign eff_idx = eff_map[6:0];
   assign sfr_sel = eff_map[4:0];
   assign setup   = psel && !penable;
   assign wr_en   = psel && penable && pwrite && pstrb[0];

   ////////////////////////////////////////////////////////////////////////////
   // Storage

   for (genvar i = 0; i < SFR_COUNT; i++)
   begin : g_sfr
      if (STORED_MASK[i])
      begin : g_cell
         always_ff @(posedge ref_clk)
         begin
            if (reset)
            begin
               // Unforced bits stay as they were
               sfr_q[i] <= (sfr_q[i] & ~RST_MASK[i]) | RST_VAL[i];
            end
            else if (wr_en && sfr_hit && (sfr_sel == 5'(i)))
            begin
               sfr_q[i] <= pwdata[7:0] & IMPL_MASK[i];
            end
         end
      end
      else
      begin : g_none
         assign sfr_q[i] = 8'h00;
      end
   end

   // General purpose cells have no reset value
   always_ff @(posedge ref_clk)
   begin
      if (wr_en && gpr_hit)
      begin
         gpr_q[eff_idx] <= pwdata[7:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read path

   always_comb
   begin
      rd_byte = 8'h00;
      if (sfr_hit)
      begin
         unique case (sfr_sel)
            IDX_PORT_A:    rd_byte = port_a_pins;
            IDX_RXDATA:    rd_byte = async_receive_data;
            IDX_CONV_HIGH: rd_byte = conversion_result_high;
            IDX_TXDATA:    rd_byte = 8'h00;
            default:       rd_byte = sfr_q[sfr_sel] & IMPL_MASK[sfr_sel];
         endcase
      end
      else if (gpr_hit)
      begin
         rd_byte = gpr_q[eff_idx];
      end
   end

   // Captured in setup so the access phase needs no wait state
   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         prdata_q <= 32'h0000_0000;
      end
      else if (setup && !pwrite)
      begin
         prdata_q <= {24'h00_0000, rd_byte};
      end
   end

   assign pready  = 1'b1;
   assign pslverr = 1'b0;
   assign prdata  = prdata_q;

   ////////////////////////////////////////////////////////////////////////////
   // Program counter upper bits

   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         pc_high_q <= 5'h00;
      end
      else if (branch_take)
      begin
         pc_high_q <= sfr_q[IDX_PROGRAM_COUNTER_UPPER_LATCH][4:0];
      end
   end

   assign pc_high = pc_high_q;

   ////////////////////////////////////////////////////////////////////////////
   // Peripheral side

   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         tx_load_q  <= 1'b0;
         wr_stb_q   <= 1'b0;
         wr_index_q <= 5'h00;
         wr_data_q  <= 8'h00;
      end
      else
      begin
         tx_load_q <= wr_en && sfr_hit && (sfr_sel == IDX_TXDATA);
         wr_stb_q  <= wr_en && sfr_hit;
         if (wr_en && sfr_hit)
         begin
            wr_index_q <= sfr_sel;
            wr_data_q  <= pwdata[7:0];
         end
      end
   end

   assign port_a_latch        = sfr_q[IDX_PORT_A];
   assign async_transmit_data = sfr_q[IDX_TXDATA];
   assign tx_load             = tx_load_q;
   assign sfr_wr_stb          = wr_stb_q;
   assign sfr_wr_index        = wr_index_q;
   assign sfr_wr_data         = wr_data_q;

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   logic [7:0] cap2_low;
   logic [7:0] program_counter_upper_latch_v;
   logic [7:0] status_v;
   assign cap2_low = sfr_q[IDX_CAP2_LOW];
   assign program_counter_upper_latch_v = sfr_q[IDX_PROGRAM_COUNTER_UPPER_LATCH];
   assign status_v = sfr_q[IDX_STATUS] & IMPL_MASK[IDX_STATUS];

   property p_unmapped_zero;
      @(posedge ref_clk) disable iff (reset)
      (setup && !pwrite && !sfr_hit && !gpr_hit) |=> (prdata == 32'h0000_0000);
   endproperty
   a_unmapped_zero:
      assert property (p_unmapped_zero) else $error("unmapped read not zero");

   property p_indirect_gpr;
      @(posedge ref_clk) disable iff (reset)
      (setup && !pwrite && use_ind && gpr_hit) |=> (prdata[7:0] == gpr_q[$past(eff_idx)]);
   endproperty
   a_indirect_gpr:
      assert property (p_indirect_gpr) else $error("indirect read wrong word");

   property p_port_pins;
      @(posedge ref_clk) disable iff (reset)
      (setup && !pwrite && sfr_hit && (sfr_sel == IDX_PORT_A)) |=> (prdata[7:0] == $past(port_a_pins));
   endproperty
   a_port_pins:
      assert property (p_port_pins) else $error("port read not pin levels");

   property p_port_latch;
      @(posedge ref_clk) disable iff (reset)
      (wr_en && sfr_hit && (sfr_sel == IDX_PORT_A)) |=> (port_a_latch == $past(pwdata[7:0]));
   endproperty
   a_port_latch:
      assert property (p_port_latch) else $error("port latch not loaded");

   property p_tx_reset;
      @(posedge ref_clk)
      reset |=> (async_transmit_data == 8'h00);
   endproperty
   a_tx_reset:
      assert property (p_tx_reset) else $error("transmit data not cleared");

   property p_cap2_kept;
      @(posedge ref_clk)
      // Case equality: contents are unknown until first written
      reset |=> (cap2_low === $past(cap2_low));
   endproperty
   a_cap2_kept:
      assert property (p_cap2_kept) else $error("capture low byte forced by reset");

   property p_conv_read;
      @(posedge ref_clk) disable iff (reset)
      (setup && !pwrite && sfr_hit && (sfr_sel == IDX_CONV_HIGH)) |=> (prdata[7:0] == $past(conversion_result_high));
   endproperty
   a_conv_read:
      assert property (p_conv_read) else $error("conversion byte misread");

   property p_branch_copy;
      @(posedge ref_clk) disable iff (reset)
      branch_take |=> (pc_high == $past(program_counter_upper_latch_v[4:0]));
   endproperty
   a_branch_copy:
      assert property (p_branch_copy) else $error("latch not copied on branch");

   property p_pc_hold;
      @(posedge ref_clk) disable iff (reset)
      (!branch_take ##1 !reset) |-> $stable(pc_high);
   endproperty
   a_pc_hold:
      assert property (p_pc_hold) else $error("upper counter moved without branch");

   property p_common_status;
      @(posedge ref_clk) disable iff (reset)
      (setup && !pwrite && (paddr[8:2] == {2'b00, IDX_STATUS})) |=> (prdata[7:0] === $past(status_v));
   endproperty
   a_common_status:
      assert property (p_common_status) else $error("status not common to banks");

endmodule
`default_nettype wire

// [hdl/sfr_bank_pkg.sv]
`default_nettype none
package sfr_bank_pkg;
   localparam int unsigned SFR_COUNT = 32;
   localparam int unsigned GPR_DEPTH = 96;
   localparam int unsigned PADDR_W   = 11;
   // Location indices; byte address is four times the index
   localparam logic [4:0] IDX_INDIRECT = 5'h00, IDX_TIMER0 = 5'h01, IDX_PCL = 5'h02, IDX_STATUS = 5'h03;
   localparam logic [4:0] IDX_POINTER = 5'h04, IDX_PORT_A = 5'h05, IDX_PORT_B = 5'h06, IDX_PORT_C = 5'h07;
   localparam logic [4:0] IDX_PORT_D = 5'h08, IDX_PORT_E = 5'h09, IDX_PROGRAM_COUNTER_UPPER_LATCH = 5'h0A, IDX_INTCTL = 5'h0B;
   localparam logic [4:0] IDX_PFLAG1 = 5'h0C, IDX_PFLAG2 = 5'h0D, IDX_TMR1_LO = 5'h0E, IDX_TMR1_HI = 5'h0F;
   localparam logic [4:0] IDX_TMR1_CTL = 5'h10, IDX_TIMER_TWO_COUNT = 5'h11, IDX_TIMER_TWO_COUNT_CTL = 5'h12, IDX_SSP_BUF = 5'h13;
   localparam logic [4:0] IDX_SSP_CTL = 5'h14, IDX_CAP1_LO = 5'h15, IDX_CAP1_HI = 5'h16, IDX_CAP1_CTL = 5'h17;
   localparam logic [4:0] IDX_RX_STAT = 5'h18, IDX_TXDATA = 5'h19, IDX_RXDATA = 5'h1A, IDX_CAP2_LOW = 5'h1B;
   localparam logic [4:0] IDX_CAP2_HI = 5'h1C, IDX_CAP2_CTL = 5'h1D, IDX_CONV_HIGH = 5'h1E, IDX_CONV_CTL = 5'h1F;
   localparam int unsigned STATUS_IRP_BIT = 7;
   localparam logic [6:0] GPR_BASE    = 7'h20;
   localparam logic [6:0] COMMON_BASE = 7'h70;
   // Locations that decode the same from every bank
   localparam logic [31:0] COMMON_MASK = 32'h0000_0C1D;
   // Locations backed by storage cells
   localparam logic [31:0] STORED_MASK = 32'hBBFF_FFFE;
   // Bits forced at reset, and the value they take
   localparam logic [7:0] RST_MASK [SFR_COUNT] = '{
      8'h00, 8'h00, 8'hFF, 8'hF8, 8'h00, 8'h2F, 8'h3F, 8'h00, 8'h00, 8'h07, 8'hFF, 8'hFE, 8'hFF, 8'hFF, 8'h00, 8'h00,
      8'hFF, 8'hFF, 8'hFF, 8'h00, 8'hFF, 8'h00, 8'h00, 8'hFF, 8'hFE, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'hFF, 8'h00, 8'hFF};
   localparam logic [7:0] RST_VAL [SFR_COUNT] = '{
      8'h00, 8'h00, 8'h00, 8'h18, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
      8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
   // Implemented bits; the rest read as zero
   localparam logic [7:0] IMPL_MASK [SFR_COUNT] = '{
      8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h0F, 8'h1F, 8'hFF, 8'hFF, 8'hEB, 8'hFF, 8'hFF,
      8'h7F, 8'hFF, 8'h7F, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h3F, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h3F, 8'hFF, 8'hFF};
endpackage
`default_nettype wire

// [verification/apb_core_model.sv]
`default_nettype none
module apb_core_model
   import sfr_bank_pkg::*;
(
   input  wire logic               ref_clk,
   input  wire logic               pready,
   input  wire logic [31:0]        prdata,
   output var  logic               psel,
   output var  logic               penable,
   output var  logic               pwrite,
   output var  logic [PADDR_W-1:0] paddr,
   output var  logic [31:0]        pwdata,
   output var  logic [3:0]         pstrb
);
   timeunit 1ns;
   timeprecision 1ps;

   initial
   begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      pstrb = 4'h0;
   end

   // One location per word; idle gap before each setup avoids a double drive
   task automatic xfer(input logic w, input logic [8:0] loc, input logic [7:0] d, output logic [7:0] r);
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {loc, 2'b00};
      pwdata <= {24'h000000, d};
      pstrb <= 4'hF;
      @(posedge ref_clk);
      penable <= 1'b1;
      @(posedge ref_clk);
      while (pready !== 1'b1)
         @(posedge ref_clk);
      r = prdata[7:0];
      psel <= 1'b0;
      penable <= 1'b0;
      // Released lines show garbage, not the last value
      paddr <= ~{loc, 2'b00};
      pwdata <= ~{24'h000000, d};
   endtask
endmodule
`default_nettype wire

// [verification/tb_core_sfr_bank_zero_map.sv]
`default_nettype none
module tb_core_sfr_bank_zero_map import sfr_bank_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic               ref_clk, reset, psel, penable, pwrite, pready, pslverr, tx_load, branch_take, sfr_wr_stb;
   logic [PADDR_W-1:0] paddr;
   logic [31:0]        pwdata, prdata;
   logic [3:0]         pstrb;
   logic [7:0]         port_a_pins, port_a_latch, async_transmit_data, async_receive_data;
   logic [7:0]         conversion_result_high, sfr_wr_data, rd;
   logic [4:0]         pc_high, sfr_wr_index;
   int                 bad_count, total_checks;

   sfr_bank dut (.ref_clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .pready, .pslverr,
      .prdata, .port_a_pins, .port_a_latch, .async_transmit_data, .tx_load, .async_receive_data,
      .conversion_result_high, .branch_take, .pc_high, .sfr_wr_stb, .sfr_wr_index, .sfr_wr_data);
   apb_core_model core (.ref_clk, .pready, .prdata, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb);

   initial
   begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end

   ////////////////////////////////////////////////////////////////
   task chk(input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task wr(input logic [8:0] loc, input logic [7:0] d);
      core.xfer(1'b1, loc, d, rd);
   endtask

   task rdc(input logic [8:0] loc, input logic [7:0] exp);
      core.xfer(1'b0, loc, 8'h00, rd);
      chk(rd, exp);
   endtask

   task wrap_up;
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////
   task t_map;
      core.xfer(1'b0, 9'h003, 8'h00, rd);
      chk(rd & 8'hF8, 8'h18);
      rdc(9'h002, 8'h00);
      rdc(9'h00C, 8'h00);
      rdc(9'h085, 8'h00);
      wr(9'h085, 8'hAA);
      rdc(9'h085, 8'h00);
      chk({7'h00, pslverr}, 8'h00);
      wr(9'h00A, 8'hFF);
      rdc(9'h00A, 8'h1F);
      async_receive_data <= 8'h3C;
      wr(9'h01A, 8'hFF);
      rdc(9'h01A, 8'h3C);
      wr(9'h013, 8'h6E);
      repeat (20) @(posedge ref_clk);
      rdc(9'h013, 8'h6E);
   endtask

   task t_indirect;
      wr(9'h004, 8'h25);
      wr(9'h000, 8'hA5);
      rdc(9'h025, 8'hA5);
      rdc(9'h000, 8'hA5);
      wr(9'h004, 8'h00);
      rdc(9'h000, 8'h00);
   endtask

   task t_port_a;
      port_a_pins <= 8'h5A;
      wr(9'h005, 8'h3C);
      #1 chk(port_a_latch, 8'h3C);
      rdc(9'h005, 8'h5A);
   endtask

   task t_transmit_reset;
      wr(9'h019, 8'h77);
      #1 chk(async_transmit_data, 8'h77);
      chk({7'h00, tx_load}, 8'h01);
      chk({7'h00, sfr_wr_stb}, 8'h01);
      chk({3'h0, sfr_wr_index}, 8'h19);
      chk(sfr_wr_data, 8'h77);
      rdc(9'h019, 8'h00);
      wr(9'h01B, 8'h9C);
      wr(9'h00A, 8'h0E);
      @(posedge ref_clk);
      reset <= 1'b1;
      repeat (2) @(posedge ref_clk);
      reset <= 1'b0;
      #1 chk(async_transmit_data, 8'h00);
      rdc(9'h01B, 8'h9C);
      rdc(9'h00A, 8'h00);
      conversion_result_high <= 8'hC3;
      rdc(9'h01E, 8'hC3);
   endtask

   task t_branch_common;
      wr(9'h18A, 8'h13);
      #1 chk({3'h0, pc_high}, 8'h00);
      rdc(9'h00A, 8'h13);
      @(posedge ref_clk);
      branch_take <= 1'b1;
      @(posedge ref_clk);
      branch_take <= 1'b0;
      #1 chk({3'h0, pc_high}, 8'h13);
      wr(9'h104, 8'h30);
      rdc(9'h084, 8'h30);
      wr(9'h0F5, 8'h5C);
      rdc(9'h075, 8'h5C);
   endtask

   ////////////////////////////////////////////////////////////////
   initial
   begin
      reset = 1'b1;
      branch_take = 1'b0;
      port_a_pins = 8'h00;
      async_receive_data = 8'h00;
      conversion_result_high = 8'h00;
      repeat (8) @(posedge ref_clk);
      reset <= 1'b0;
      #1 chk(async_transmit_data, 8'h00);
      t_map();
      t_indirect();
      t_port_a();
      t_transmit_reset();
      t_branch_common();
      wrap_up();
   end

   // Whole run is about 130 cycles
   initial
   begin
      repeat (5000) @(posedge ref_clk);
      bad_count++;
      wrap_up();
   end
endmodule
`default_nettype wire
